/* core/cwsl_loader.sv */
// Configuration word shadow loader top
`timescale 1ns/1ps
module cwsl_loader (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       clkEn,
  input  wire logic                       dualPartition,
  input  wire logic                       fetchValid,
  input  wire logic [cwsl_pkg::ADDR_W-1:0] fetchAddr,
  input  wire logic                       lastPageErase,
  output logic                            flashRdEn,
  output logic      [cwsl_pkg::ADDR_W-1:0] flashRdAddr,
  input  wire logic [cwsl_pkg::DATA_W-1:0] flashRdData,
  input  wire logic                       flashRdValid,
  output logic                            cfgEraseReq,
  output logic      [cwsl_pkg::ADDR_W-1:0] cfgEraseBase,
  output logic                            activePanel,
  output logic                            shadowValid,
  output logic                            coreResetHold,
  output logic                            cfgFetchReset,
  output logic      [cwsl_pkg::NUM_WORDS*cwsl_pkg::DATA_W-1:0] shadowWords
);
  import cwsl_pkg::*;

  cwsl_state_t          state_q;
  logic [IDX_W-1:0]     idx_q;
  logic [DATA_W-1:0]    shadow_q [NUM_WORDS];
  logic [SEQ_W-1:0]     seq0_q;
  logic [ADDR_W-1:0]    base_q;
  logic                 fetchHit;

  // Fetch inside either panel's configuration block
  assign fetchHit = fetchValid &&
    (((fetchAddr >= PANEL0_CFG_BASE) && (fetchAddr < PANEL0_CFG_BASE + CFG_SPAN)) ||
     ((fetchAddr >= PANEL1_CFG_BASE) && (fetchAddr < PANEL1_CFG_BASE + CFG_SPAN)));

  // self reset pulse; restarts loader next cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfgFetchReset <= 1'b0;
    end else if (clkEn) begin
      cfgFetchReset <= fetchHit && (state_q == ST_DONE);
    end
  end

  // sequencer; restarts on every reset incl. fetch reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      idx_q       <= '0;
      flashRdEn   <= 1'b0;
      flashRdAddr <= '0;
      seq0_q      <= '0;
      base_q      <= PANEL0_CFG_BASE;
      activePanel <= 1'b0;
    end else if (clkEn) begin
      flashRdEn <= 1'b0;
      if (cfgFetchReset) begin
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            idx_q       <= '0;
            base_q      <= PANEL0_CFG_BASE;
            activePanel <= 1'b0;
            flashRdEn   <= 1'b1;
            flashRdAddr <= cfgAddr(PANEL0_CFG_BASE, BOOT_SEQ_IDX);
            state_q     <= dualPartition ? ST_SEQ0 : ST_LOAD;
          end
          ST_SEQ0: begin
            if (flashRdValid) begin
              seq0_q      <= flashRdData[SEQ_W-1:0];
              flashRdEn   <= 1'b1;
              flashRdAddr <= cfgAddr(PANEL1_CFG_BASE, BOOT_SEQ_IDX);
              state_q     <= ST_SEQ1;
            end
          end
          ST_SEQ1: begin
            if (flashRdValid) begin
              // lower sequence number wins; tie keeps panel 0
              if (flashRdData[SEQ_W-1:0] < seq0_q) begin
                activePanel <= 1'b1;
                base_q      <= PANEL1_CFG_BASE;
              end
              state_q <= ST_LOAD;
            end
          end
          ST_LOAD: begin
            // only the active panel's words are read
            flashRdEn   <= 1'b1;
            flashRdAddr <= cfgAddr(base_q, idx_q);
            state_q     <= ST_WAIT;
          end
          ST_WAIT: begin
            if (flashRdValid) begin
              if (idx_q == IDX_W'(NUM_WORDS - 1)) begin
                state_q <= ST_DONE;
              end else begin
                idx_q   <= idx_q + 1'b1;
                state_q <= ST_LOAD;
              end
            end
          end
          ST_DONE: state_q <= ST_DONE;
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        shadow_q[i] <= '0;
      end
    end else if (clkEn && (state_q == ST_WAIT) && flashRdValid && !cfgFetchReset) begin
      shadow_q[idx_q] <= flashRdData;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_WORDS; i++) begin
      shadowWords[i*DATA_W +: DATA_W] = shadow_q[i];
    end
  end

  // valid only after a full load; core held until then
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shadowValid   <= 1'b0;
      coreResetHold <= 1'b1;
    end else if (clkEn) begin
      shadowValid   <= (state_q == ST_DONE) && !cfgFetchReset;
      coreResetHold <= !((state_q == ST_DONE) && !cfgFetchReset);
    end
  end

  // last page erase also erases the active configuration words
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfgEraseReq  <= 1'b0;
      cfgEraseBase <= '0;
    end else if (clkEn) begin
      cfgEraseReq  <= lastPageErase && (state_q == ST_DONE);
      cfgEraseBase <= base_q;
    end
  end

  chk_hold_until_valid: assert property (@(posedge ref_clk) disable iff (rst)
    shadowValid |-> !coreResetHold) else $error("core released state mismatch");
  chk_fetch_reload: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && cfgFetchReset) |=> (state_q == ST_IDLE)) else $error("no reload after fetch");
  chk_invalid_loading: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == ST_LOAD) |-> !shadowValid) else $error("valid during load");
  chk_panel_reads: assert property (@(posedge ref_clk) disable iff (rst)
    ($past(state_q) == ST_LOAD && flashRdEn) |-> (flashRdAddr[ADDR_W-1:4] == base_q[ADDR_W-1:4]))
    else $error("read outside active panel");
  chk_word_capture: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && state_q == ST_WAIT && flashRdValid && !cfgFetchReset)
    |=> (shadow_q[$past(idx_q)] == $past(flashRdData))) else $error("word not captured");
  // panel choice fixed after sequence compare
  chk_panel_stable: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == ST_DONE && $past(state_q) == ST_DONE) |-> $stable(activePanel))
    else $error("panel changed after load");
  chk_load_step: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && state_q == ST_LOAD && !cfgFetchReset) |=> (state_q == ST_WAIT && flashRdEn))
    else $error("load step skipped");
  chk_erase_gate: assert property (@(posedge ref_clk) disable iff (rst)
    cfgEraseReq |-> $past(state_q) == ST_DONE) else $error("erase before load");

  // Fetch hit while loaded and running
  sequence fetchHitInDone;
    clkEn && fetchHit && (state_q == ST_DONE);
  endsequence

  // Pulse taken, then loader back in idle with core held
  sequence reloadStarted;
    (cfgFetchReset && clkEn) ##1 (state_q == ST_IDLE && coreResetHold && !shadowValid);
  endsequence

  // fetch in configuration space forces a reload
  chk_fetch_forces_reset: assert property (@(posedge ref_clk) disable iff (rst)
    fetchHitInDone |=> reloadStarted) else $error("fetch hit gave no reset");

  // Last word captured by the sequencer
  sequence lastWordTaken;
    clkEn && (state_q == ST_WAIT) && flashRdValid && !cfgFetchReset &&
      (idx_q == IDX_W'(NUM_WORDS - 1));
  endsequence

  // core released one cycle after the last word lands
  chk_release_after_load: assert property (@(posedge ref_clk) disable iff (rst)
    lastWordTaken ##1 (clkEn && state_q == ST_DONE) |=> (shadowValid && !coreResetHold))
    else $error("core not released after load");

  // first read always targets the sequence word of panel 0
  chk_first_read: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && state_q == ST_IDLE && !cfgFetchReset)
    |=> (flashRdEn && flashRdAddr == cfgAddr(PANEL0_CFG_BASE, BOOT_SEQ_IDX)))
    else $error("first read misplaced");

  // erase request names the active panel
  chk_erase_base: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && lastPageErase && state_q == ST_DONE)
    |=> (cfgEraseReq && cfgEraseBase == $past(base_q)))
    else $error("erase request missing");

  // Frozen clock enable must not disturb loaded state
  chk_freeze_state: assert property (@(posedge ref_clk) disable iff (rst)
    !clkEn |=> ($stable(state_q) && $stable(shadowValid) && $stable(cfgFetchReset)))
    else $error("state moved while frozen");
endmodule : cwsl_loader

/* core/cwsl_pkg.sv */
// Constants and types for the configuration word shadow loader
// Overview of operation
// - Shadow registers are volatile; invalid after power-up until filled from flash.
// - Configuration words are read from the highest program memory addresses.
// - During reset each flash word is copied into its shadow register automatically.
// - The load repeats after every reset source, not only power-on.
// - In dual-partition mode the 12-bit boot sequence field picks the active panel.
// - In dual-partition mode only the active panel's words are loaded.
// - An instruction fetch inside configuration space forces a device reset.
// - Erasing the last program page clears the active panel's flash configuration words.
package cwsl_pkg;
  localparam int          ADDR_W       = 24;
  localparam int          DATA_W       = 24;
  localparam int          NUM_WORDS    = 8;
  localparam int          IDX_W        = 3;
  localparam int          SEQ_W        = 12;
  // Word index of the boot sequence word within the configuration block
  localparam logic [IDX_W-1:0] BOOT_SEQ_IDX = 3'h0;
  // Panel top addresses; plain defaults
  localparam logic [ADDR_W-1:0] PANEL0_CFG_BASE = 24'h00_AF80;
  localparam logic [ADDR_W-1:0] PANEL1_CFG_BASE = 24'h40_AF80;
  localparam logic [ADDR_W-1:0] CFG_SPAN       = 24'h00_0010;
  localparam logic [ADDR_W-1:0] WORD_STEP      = 24'h00_0002;
  localparam logic [DATA_W-1:0] ERASED_WORD    = 24'hFF_FFFF;
  localparam int          READ_LAT     = 2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SEQ0  = 3'b001,
    ST_SEQ1  = 3'b011,
    ST_LOAD  = 3'b010,
    ST_WAIT  = 3'b110,
    ST_DONE  = 3'b111
  } cwsl_state_t;

  function automatic logic [ADDR_W-1:0] cfgAddr(input logic [ADDR_W-1:0] base,
                                                input logic [IDX_W-1:0] idx);
    cfgAddr = base + ADDR_W'(idx) * WORD_STEP;
  endfunction : cfgAddr
endpackage : cwsl_pkg

/* testbench/cwsl_flash_model.sv */
// Flash array read port model for the shadow loader
`timescale 1ns/1ps
module cwsl_flash_model #(
  parameter int LAT = 2
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       rdEn,
  input  wire logic [cwsl_pkg::ADDR_W-1:0] rdAddr,
  output logic      [cwsl_pkg::DATA_W-1:0] rdData,
  output logic                            rdValid,
  input  wire logic                       erase,
  input  wire logic [cwsl_pkg::ADDR_W-1:0] eraseBase,
  output logic                            badAddr
);
  import cwsl_pkg::*;
  logic [DATA_W-1:0] mem [2][NUM_WORDS];
  logic [ADDR_W-1:0] addrQ;
  int                cnt;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdValid <= 1'h0;
      cnt     <= 0;
      rdData  <= 24'h00_0000;
      badAddr <= 1'h0;
    end else begin
      rdValid <= 1'h0;
      // Released bus keeps toggling so stale data never matches
      rdData  <= ~rdData;
      if (rdEn) begin
        addrQ <= rdAddr;
        cnt   <= LAT;
        if ((rdAddr & ~24'h40_000E) !== PANEL0_CFG_BASE) badAddr <= 1'h1;
      end else if (cnt == 1) begin
        rdValid <= 1'h1;
        rdData  <= mem[addrQ[22]][addrQ[3:1]];
        cnt     <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
      if (erase) for (int i = 0; i < NUM_WORDS; i++) mem[eraseBase[22]][i] <= ERASED_WORD;
    end
  end
endmodule : cwsl_flash_model

/* testbench/tb.sv */
// Self-checking bench for the shadow loader
`timescale 1ns/1ps
module tb;
  import cwsl_pkg::*;
  logic ref_clk = 1'h0, rst = 1'h1, dualPartition = 1'h0, fetchValid = 1'h0, lastPageErase = 1'h0;
  logic [ADDR_W-1:0] fetchAddr = 24'h00_0000, flashRdAddr, cfgEraseBase;
  logic [DATA_W-1:0] flashRdData;
  logic flashRdEn, flashRdValid, cfgEraseReq, activePanel, shadowValid, coreResetHold;
  logic cfgFetchReset, badAddr, clkEn = 1'h1;
  logic [NUM_WORDS*DATA_W-1:0] shadowWords;
  int failures = 0, check_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  cwsl_loader cwsl_loader_i (.ref_clk, .rst, .clkEn, .dualPartition, .fetchValid,
    .fetchAddr, .lastPageErase, .flashRdEn, .flashRdAddr, .flashRdData, .flashRdValid,
    .cfgEraseReq, .cfgEraseBase, .activePanel, .shadowValid, .coreResetHold, .cfgFetchReset,
    .shadowWords);
  cwsl_flash_model cwsl_flash_model_i (.ref_clk, .rst, .rdEn(flashRdEn), .rdAddr(flashRdAddr),
    .rdData(flashRdData), .rdValid(flashRdValid), .erase(cfgEraseReq),
    .eraseBase(cfgEraseBase), .badAddr);
  function automatic logic [23:0] ew(input logic p, input int i, input logic [11:0] s);
    return (i == 0) ? {11'h000, p, s} : {p ? 8'h5A : 8'hC3, 4'(i), 12'h321};
  endfunction : ew
  task automatic check(input string n, input logic [23:0] s, input logic [23:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic fill(input logic [11:0] s0, input logic [11:0] s1);
    for (int i = 0; i < NUM_WORDS; i++) begin
      cwsl_flash_model_i.mem[0][i] = ew(1'h0, i, s0);
      cwsl_flash_model_i.mem[1][i] = ew(1'h1, i, s1);
    end
  endtask : fill
  task automatic doReset;
    rst = 1'h1;
    repeat (20) @(negedge ref_clk);
    check("hold", 24'(coreResetHold), 24'h00_0001);
    check("valid", 24'(shadowValid), 24'h00_0000);
    rst = 1'h0;
  endtask : doReset
  task automatic waitLoad(input logic p, input logic [11:0] s);
    int n;
    n = 0;
    while (shadowValid !== 1'h1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    check("release", 24'(coreResetHold), 24'h00_0000);
    check("panel", 24'(activePanel), 24'(p));
    check("addr", 24'(badAddr), 24'h00_0000);
    for (int i = 0; i < NUM_WORDS; i++) check("word", shadowWords[i*24+:24], ew(p, i, s));
  endtask : waitLoad
  task automatic fetchAt(input logic [23:0] a);
    fetchAddr = a;
    fetchValid = 1'h1;
    @(negedge ref_clk);
    fetchValid = 1'h0;
  endtask : fetchAt
  task automatic testFetch;
    int n;
    fetchAt(24'h00_1000);
    repeat (3) @(negedge ref_clk);
    check("nofetchrst", 24'(shadowValid), 24'h00_0001);
    fill(12'h0AA, 12'h100);
    fetchAt(PANEL0_CFG_BASE + 24'h00_0002);
    n = 0;
    while (cfgFetchReset !== 1'h1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    check("fetchrst", 24'(cfgFetchReset), 24'h00_0001);
    @(negedge ref_clk);
    check("refetchhold", 24'(coreResetHold), 24'h00_0001);
    waitLoad(1'h0, 12'h0AA);
  endtask : testFetch
  task automatic testFreeze;
    clkEn = 1'h0;
    fetchAt(PANEL0_CFG_BASE);
    repeat (2) @(negedge ref_clk);
    check("frozenrst", 24'(cfgFetchReset), 24'h00_0000);
    check("frozenvalid", 24'(shadowValid), 24'h00_0001);
    clkEn = 1'h1;
    @(negedge ref_clk);
    check("thawvalid", 24'(shadowValid), 24'h00_0001);
  endtask : testFreeze
  task automatic testErase;
    lastPageErase = 1'h1;
    @(negedge ref_clk);
    lastPageErase = 1'h0;
    @(negedge ref_clk);
    doReset();
    repeat (60) @(negedge ref_clk);
    for (int i = 0; i < NUM_WORDS; i++) check("erased", shadowWords[i*24+:24], ERASED_WORD);
  endtask : testErase
  task automatic summarize;
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    #25000;
    failures++;
    summarize();
  end
  initial begin
    fill(12'h800, 12'h100);
    doReset();
    waitLoad(1'h0, 12'h800);
    dualPartition = 1'h1;
    doReset();
    waitLoad(1'h1, 12'h100);
    dualPartition = 1'h0;
    doReset();
    waitLoad(1'h0, 12'h800);
    testFreeze();
    testFetch();
    testErase();
    summarize();
  end
endmodule : tb
